// file: pin_config_pkg.sv
// Shared constants, types and decode function for the port 5/6 pin setup
package pin_config_pkg;

    // ==========================================================
    // Geometry
    localparam int PIN_COUNT = 8;
    localparam int FIELD_WIDTH = 2;
    localparam int REG_WIDTH = 8;

    // ==========================================================
    // Register offsets in the register-direct address space
    localparam logic [7:0] PORT5_HIGH_OFFSET = 8'hf0;
    localparam logic [7:0] PORT5_LOW_OFFSET = 8'hf1;
    localparam logic [7:0] PORT6_HIGH_OFFSET = 8'hf2;
    localparam logic [7:0] PORT6_LOW_OFFSET = 8'hf3;
    localparam logic [7:0] PORT6_PULLUP_OFFSET = 8'hf4;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Two-bit configuration codes
    localparam logic [1:0] CODE_INPUT = 2'h0;
    localparam logic [1:0] CODE_PULLUP_OR_SERIAL = 2'h1;
    localparam logic [1:0] CODE_ALT = 2'h2;
    localparam logic [1:0] CODE_OUTPUT = 2'h3;

    // ==========================================================
    // Pins that carry special alternate functions
    localparam int XTAL_IN_PIN = 7;
    localparam int XTAL_OUT_PIN = 6;
    localparam int SERIAL_OUT_PIN = 2;
    localparam int SERIAL_IN_PIN = 1;
    localparam int SERIAL_CLK_PIN = 0;
    localparam logic SERIAL_IDLE = 1'b1;

    // ==========================================================
    // Decoded mode of one pin
    typedef struct packed {
        logic drive;
        logic alt_main;
        logic alt_serial;
        logic input_mode;
        logic code_pullup;
    } pin_mode_type;

    // Reserved codes fall back to plain input with the driver off
    function automatic pin_mode_type decode_field(
        input logic [1:0] code,
        input logic alt_main_ok,
        input logic alt_serial_ok,
        input logic pullup_ok
    );
        pin_mode_type m;
        m = '0;
        case (code)
            CODE_INPUT: begin
                m.input_mode = 1'b1;
            end
            CODE_PULLUP_OR_SERIAL: begin
                if (pullup_ok) begin
                    m.input_mode = 1'b1;
                    m.code_pullup = 1'b1;
                end else if (alt_serial_ok) begin
                    m.alt_serial = 1'b1;
                end else begin
                    m.input_mode = 1'b1;
                end
            end
            CODE_ALT: begin
                if (alt_main_ok) begin
                    m.alt_main = 1'b1;
                end else begin
                    m.input_mode = 1'b1;
                end
            end
            CODE_OUTPUT: begin
                m.drive = 1'b1;
            end
            default: begin
                m.input_mode = 1'b1;
            end
        endcase
        return m;
    endfunction

endpackage

// file: pin_mode_if.sv
// Configuration bytes out, decoded pin modes back
`timescale 1ns/100ps
interface pin_mode_if;
    import pin_config_pkg::*;

    // ==========================================================
    // Configuration bytes held by the register file
    logic [REG_WIDTH-1:0] port5_high;
    logic [REG_WIDTH-1:0] port5_low;
    logic [REG_WIDTH-1:0] port6_high;
    logic [REG_WIDTH-1:0] port6_low;

    // ==========================================================
    // Decoded modes, one entry per pin
    pin_mode_type port5_mode [PIN_COUNT];
    pin_mode_type port6_mode [PIN_COUNT];

    modport owner (
        output port5_high, port5_low, port6_high, port6_low,
        input port5_mode, port6_mode
    );
    modport decoder (
        input port5_high, port5_low, port6_high, port6_low,
        output port5_mode, port6_mode
    );
endinterface

// file: pin_mode_decoder.sv
// Per-pin decode of the port 5 and port 6 configuration fields
`timescale 1ns/100ps
module pin_mode_decoder (
    // Configuration in, modes out
    pin_mode_if.decoder cfg
);
    import pin_config_pkg::*;

    logic [2*REG_WIDTH-1:0] port5_fields;
    logic [2*REG_WIDTH-1:0] port6_fields;

    // High byte serves pins 7..4, low byte pins 3..0
    assign port5_fields = {cfg.port5_high, cfg.port5_low};
    assign port6_fields = {cfg.port6_high, cfg.port6_low};

    // ==========================================================
    // Pin decode
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        // Port 5: pull-up code everywhere, crystal only on 7 and 6
        assign cfg.port5_mode[i] = decode_field(
            port5_fields[FIELD_WIDTH*i +: FIELD_WIDTH],
            (i == XTAL_IN_PIN) || (i == XTAL_OUT_PIN),
            1'b0,
            1'b1);
        // Port 6: LCD everywhere, serial outputs only on 2 and 0
        assign cfg.port6_mode[i] = decode_field(
            port6_fields[FIELD_WIDTH*i +: FIELD_WIDTH],
            1'b1,
            (i == SERIAL_OUT_PIN) || (i == SERIAL_CLK_PIN),
            1'b0);
    end

endmodule

// file: port56_pin_config.sv
// Port 5 and port 6 pin configuration registers and pin control
`timescale 1ns/100ps
module port56_pin_config (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register-direct access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    // Port data registers and sampled levels
    input wire logic [pin_config_pkg::PIN_COUNT-1:0] port5_data_out,
    input wire logic [pin_config_pkg::PIN_COUNT-1:0] port6_data_out,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port5_pin_level,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port6_pin_level,
    // Port 5 pads
    input wire logic [pin_config_pkg::PIN_COUNT-1:0] port5_pin_in,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port5_pin_out,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port5_pin_oe,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port5_pullup_on,
    // Port 6 pads
    input wire logic [pin_config_pkg::PIN_COUNT-1:0] port6_pin_in,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port6_pin_out,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port6_pin_oe,
    output logic [pin_config_pkg::PIN_COUNT-1:0] port6_pullup_on,
    // Alternate function hookups
    output logic subosc_crystal_in,
    output logic subosc_crystal_out,
    output logic [pin_config_pkg::PIN_COUNT-1:0] lcd_segment_pin,
    input wire logic serial_data_out,
    input wire logic serial_clock_out,
    output logic serial_data_in,
    output logic serial_clock_in
);
    import pin_config_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [REG_WIDTH-1:0] port5_high;
        logic [REG_WIDTH-1:0] port5_low;
        logic [REG_WIDTH-1:0] port6_high;
        logic [REG_WIDTH-1:0] port6_low;
        logic [REG_WIDTH-1:0] pullup_en;
        logic [REG_WIDTH-1:0] rdata;
        logic [2*PIN_COUNT-1:0] sync_first;
        logic [2*PIN_COUNT-1:0] sync_second;
        logic [PIN_COUNT-1:0] p5_out;
        logic [PIN_COUNT-1:0] p5_oe;
        logic [PIN_COUNT-1:0] p5_pull;
        logic [PIN_COUNT-1:0] p6_out;
        logic [PIN_COUNT-1:0] p6_oe;
        logic [PIN_COUNT-1:0] p6_pull;
        logic [PIN_COUNT-1:0] lcd_en;
        logic xtal_in_en;
        logic xtal_out_en;
        logic ser_din;
        logic ser_clk;
    } state_type;

    state_type state_reg;
    state_type state_next;

    pin_mode_if mode_bus ();

    // Configuration bytes go to the decoder straight from the flops
    assign mode_bus.port5_high = state_reg.port5_high;
    assign mode_bus.port5_low = state_reg.port5_low;
    assign mode_bus.port6_high = state_reg.port6_high;
    assign mode_bus.port6_low = state_reg.port6_low;

    pin_mode_decoder u_decoder (
        .cfg (mode_bus.decoder)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        // Pads are asynchronous to clk; two flops before any use
        state_next.sync_first = {port6_pin_in, port5_pin_in};
        state_next.sync_second = state_reg.sync_first;

        // Register-direct writes; every bit is stored
        if (reg_write) begin
            case (reg_addr)
                PORT5_HIGH_OFFSET: state_next.port5_high = reg_wdata;
                PORT5_LOW_OFFSET: state_next.port5_low = reg_wdata;
                PORT6_HIGH_OFFSET: state_next.port6_high = reg_wdata;
                PORT6_LOW_OFFSET: state_next.port6_low = reg_wdata;
                PORT6_PULLUP_OFFSET: state_next.pullup_en = reg_wdata;
                default: begin
                end
            endcase
        end

        // Reads have no side effect, so the data is refreshed each cycle
        case (reg_addr)
            PORT5_HIGH_OFFSET: state_next.rdata = state_reg.port5_high;
            PORT5_LOW_OFFSET: state_next.rdata = state_reg.port5_low;
            PORT6_HIGH_OFFSET: state_next.rdata = state_reg.port6_high;
            PORT6_LOW_OFFSET: state_next.rdata = state_reg.port6_low;
            PORT6_PULLUP_OFFSET: state_next.rdata = state_reg.pullup_en;
            default: state_next.rdata = UNMAPPED_READ;
        endcase

        // Pin control from the decoded modes
        for (int i = 0; i < PIN_COUNT; i++) begin
            // Reserved codes decode to input, so no driver here
            state_next.p5_oe[i] = mode_bus.port5_mode[i].drive;
            state_next.p5_out[i] = port5_data_out[i];
            state_next.p5_pull[i] = mode_bus.port5_mode[i].code_pullup;
            state_next.p6_oe[i] = mode_bus.port6_mode[i].drive
                | mode_bus.port6_mode[i].alt_serial;
            state_next.p6_out[i] = port6_data_out[i];
            // Pull-up only while the pin is an input
            state_next.p6_pull[i] = mode_bus.port6_mode[i].input_mode
                & state_reg.pullup_en[i];
            state_next.lcd_en[i] = mode_bus.port6_mode[i].alt_main;
        end
        // Serial engine owns the driven level on its alternate pins
        if (mode_bus.port6_mode[SERIAL_OUT_PIN].alt_serial) begin
            state_next.p6_out[SERIAL_OUT_PIN] = serial_data_out;
        end
        if (mode_bus.port6_mode[SERIAL_CLK_PIN].alt_serial) begin
            state_next.p6_out[SERIAL_CLK_PIN] = serial_clock_out;
        end

        // Crystal pins: driver and pull-up already off in this mode
        state_next.xtal_in_en =
            mode_bus.port5_mode[XTAL_IN_PIN].alt_main;
        state_next.xtal_out_en =
            mode_bus.port5_mode[XTAL_OUT_PIN].alt_main;

        // Serial inputs idle high when the pin is not an input
        state_next.ser_din = SERIAL_IDLE;
        state_next.ser_clk = SERIAL_IDLE;
        if (mode_bus.port6_mode[SERIAL_IN_PIN].input_mode) begin
            state_next.ser_din =
                state_reg.sync_second[PIN_COUNT + SERIAL_IN_PIN];
        end
        if (mode_bus.port6_mode[SERIAL_CLK_PIN].input_mode) begin
            state_next.ser_clk =
                state_reg.sync_second[PIN_COUNT + SERIAL_CLK_PIN];
        end

        // Synchronous reset: every pin back to plain input
        if (!reset_n) begin
            state_next = '0;
            state_next.port5_high = CONFIG_RESET;
            state_next.port5_low = CONFIG_RESET;
            state_next.port6_high = CONFIG_RESET;
            state_next.port6_low = CONFIG_RESET;
            state_next.pullup_en = CONFIG_RESET;
            state_next.ser_din = SERIAL_IDLE;
            state_next.ser_clk = SERIAL_IDLE;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign reg_rdata = state_reg.rdata;
    assign port5_pin_level = state_reg.sync_second[PIN_COUNT-1:0];
    assign port6_pin_level = state_reg.sync_second[2*PIN_COUNT-1:PIN_COUNT];
    assign port5_pin_out = state_reg.p5_out;
    assign port5_pin_oe = state_reg.p5_oe;
    assign port5_pullup_on = state_reg.p5_pull;
    assign port6_pin_out = state_reg.p6_out;
    assign port6_pin_oe = state_reg.p6_oe;
    assign port6_pullup_on = state_reg.p6_pull;
    assign subosc_crystal_in = state_reg.xtal_in_en;
    assign subosc_crystal_out = state_reg.xtal_out_en;
    assign lcd_segment_pin = state_reg.lcd_en;
    assign serial_data_in = state_reg.ser_din;
    assign serial_clock_in = state_reg.ser_clk;

    // ==========================================================
    // Checks
    xtal_in_mode_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port5_high[7:6] == CODE_ALT |=>
            subosc_crystal_in && !port5_pin_oe[7] && !port5_pullup_on[7])
        else $error("crystal in mode not applied");

    xtal_out_mode_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port5_high[5:4] == CODE_ALT |=>
            subosc_crystal_out && !port5_pin_oe[6])
        else $error("crystal out mode not applied");

    reserved_input_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port5_high[3:2] == CODE_ALT |=>
            !port5_pin_oe[5] && !port5_pullup_on[5])
        else $error("reserved code drove pin 5.5");

    port5_output_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port5_low[1:0] == CODE_OUTPUT |=>
            port5_pin_oe[0] && port5_pin_out[0] == $past(port5_data_out[0]))
        else $error("pin 5.0 output not driven from data");

    port5_pullup_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port5_low[7:6] == CODE_PULLUP_OR_SERIAL |=>
            port5_pullup_on[3] && !port5_pin_oe[3])
        else $error("pin 5.3 pull-up missing");

    lcd_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.port6_high[7:6] == CODE_ALT |=>
            lcd_segment_pin[7] && !port6_pin_oe[7] && !port6_pullup_on[7])
        else $error("pin 6.7 LCD mode wrong");

    serial_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.port6_low[5:4] == CODE_PULLUP_OR_SERIAL |=>
            port6_pin_oe[2] && port6_pin_out[2] == $past(serial_data_out))
        else $error("serial data not on pin 6.2");

    serial_in_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.port6_low[3:2] == CODE_INPUT |=>
            serial_data_in == $past(port6_pin_level[1]))
        else $error("pin 6.1 not fed to serial input");

    serial_clock_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port6_low[1:0] == CODE_PULLUP_OR_SERIAL |=>
            port6_pin_oe[0] && port6_pin_out[0] == $past(serial_clock_out))
        else $error("serial clock not on pin 6.0");

    pullup_force_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port6_low[7:6] == CODE_OUTPUT |=> !port6_pullup_on[3])
        else $error("pull-up left on with output");

    pullup_enable_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        state_reg.port6_high[1:0] == CODE_INPUT && state_reg.pullup_en[4]
            |=> port6_pullup_on[4])
        else $error("enabled pull-up not applied");

    reset_clear_a: assert property (@(posedge clk)
        $rose(reset_n) |-> state_reg.port5_high == CONFIG_RESET
            && state_reg.pullup_en == CONFIG_RESET && port6_pin_oe == '0)
        else $error("registers not cleared by reset");

    write_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_write && reg_addr == PORT6_LOW_OFFSET ##1 !reg_write
            && reg_addr == PORT6_LOW_OFFSET
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read back differs from write");

    level_sample_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        $past(reset_n, 2) |-> port5_pin_level == $past(port5_pin_in, 2))
        else $error("pin level not sampled through two flops");

endmodule

// file: pad_board.sv
// Board model for one 8-pin port: pad level from driver, source or pull-up
`timescale 1ns/100ps
module pad_board (
    // Clock
    input wire logic clk,
    // Device pad controls
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    // External source on the board
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_level,
    // Level seen at the pad
    output logic [7:0] pin_in
);
    logic [7:0] last_reg = 8'h00;

    // ==========================================================
    // Pad resolution
    // A pad nobody drives or pulls shows the inverse of its last level,
    // so a design that relies on a floating pin cannot pass by luck
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] :
                ext_drive[i] ? ext_level[i] :
                pullup_on[i] ? 1'b1 : ~last_reg[i];
        end
    end

    // Remember the level for the floating case
    always_ff @(posedge clk) begin
        last_reg <= pin_in;
    end
endmodule

// file: tb_top.sv
// Self-checking bench for the port 5/6 pin configuration block
`timescale 1ns/100ps
module tb_top;
    import pin_config_pkg::*;

    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] port5_data_out = 8'h00;
    logic [7:0] port6_data_out = 8'h00;
    logic [7:0] port5_pin_level, port6_pin_level;
    logic [7:0] port5_pin_in, port6_pin_in;
    logic [7:0] port5_pin_out, port6_pin_out;
    logic [7:0] port5_pin_oe, port6_pin_oe;
    logic [7:0] port5_pullup_on, port6_pullup_on;
    logic subosc_crystal_in, subosc_crystal_out;
    logic [7:0] lcd_segment_pin;
    logic serial_data_out = 1'b0;
    logic serial_clock_out = 1'b0;
    logic serial_data_in, serial_clock_in;
    logic [7:0] ext5_drive = 8'h00;
    logic [7:0] ext5_level = 8'h00;
    logic [7:0] ext6_drive = 8'h00;
    logic [7:0] ext6_level = 8'h00;
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] offs [5] = '{PORT5_HIGH_OFFSET, PORT5_LOW_OFFSET,
        PORT6_HIGH_OFFSET, PORT6_LOW_OFFSET, PORT6_PULLUP_OFFSET};

    // Clock at 125 MHz
    always #4 clk = ~clk;

    // ==========================================================
    // Device and board
    port56_pin_config port56_pin_config_i (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata), .port5_data_out(port5_data_out),
        .port6_data_out(port6_data_out), .port5_pin_level(port5_pin_level),
        .port6_pin_level(port6_pin_level), .port5_pin_in(port5_pin_in),
        .port5_pin_out(port5_pin_out), .port5_pin_oe(port5_pin_oe),
        .port5_pullup_on(port5_pullup_on), .port6_pin_in(port6_pin_in),
        .port6_pin_out(port6_pin_out), .port6_pin_oe(port6_pin_oe),
        .port6_pullup_on(port6_pullup_on),
        .subosc_crystal_in(subosc_crystal_in),
        .subosc_crystal_out(subosc_crystal_out),
        .lcd_segment_pin(lcd_segment_pin),
        .serial_data_out(serial_data_out),
        .serial_clock_out(serial_clock_out),
        .serial_data_in(serial_data_in), .serial_clock_in(serial_clock_in));
    pad_board pad_board5_i (.clk(clk), .pin_out(port5_pin_out),
        .pin_oe(port5_pin_oe), .pullup_on(port5_pullup_on),
        .ext_drive(ext5_drive), .ext_level(ext5_level),
        .pin_in(port5_pin_in));
    pad_board pad_board6_i (.clk(clk), .pin_out(port6_pin_out),
        .pin_oe(port6_pin_oe), .pullup_on(port6_pullup_on),
        .ext_drive(ext6_drive), .ext_level(ext6_level),
        .pin_in(port6_pin_in));

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Write pulse, then wait until the pads reflect it (two edges later)
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // Read data is registered: one edge after the address is presented
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
    endtask

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_values();
        logic [7:0] d;
        foreach (offs[i]) begin
            rd(offs[i], d);
            check("reset value", d, CONFIG_RESET);
        end
        check("oe5 at reset", port5_pin_oe, 8'h00);
        check("pull6 at reset", port6_pullup_on, 8'h00);
    endtask

    // Every bit both ways, plus a write and read of an unmapped place
    task automatic reg_access();
        logic [7:0] d;
        wr(8'hf5, 8'hff);
        rd(8'hf5, d);
        check("unmapped read", d, UNMAPPED_READ);
        foreach (offs[i]) begin
            wr(offs[i], 8'ha5);
            rd(offs[i], d);
            check("readback a5", d, 8'ha5);
            wr(offs[i], 8'h5a);
            rd(offs[i], d);
            check("readback 5a", d, 8'h5a);
        end
    endtask

    // Crystal codes, a reserved code and pull-up codes on port 5
    task automatic port5_modes();
        port5_data_out = 8'h5a;
        wr(PORT5_HIGH_OFFSET, 8'ha9);
        wr(PORT5_LOW_OFFSET, 8'he7);
        check("crystal", {6'h0, subosc_crystal_in, subosc_crystal_out},
              8'h03);
        check("oe5", port5_pin_oe, 8'h09);
        check("pull5", port5_pullup_on, 8'h12);
        check("out5", port5_pin_out & port5_pin_oe, 8'h08);
        wr(PORT5_HIGH_OFFSET, 8'hff);
        check("crystal off", {6'h0, subosc_crystal_in, subosc_crystal_out},
              8'h00);
        check("oe5 out", port5_pin_oe, 8'hf9);
        check("out5 data", port5_pin_out & port5_pin_oe, 8'h58);
    endtask

    // LCD, serial outputs, reserved codes and pull-up masking on port 6
    task automatic port6_modes();
        port6_data_out = 8'hc3;
        serial_data_out = 1'b1;
        serial_clock_out = 1'b0;
        wr(PORT6_PULLUP_OFFSET, 8'hff);
        wr(PORT6_HIGH_OFFSET, 8'he4);
        wr(PORT6_LOW_OFFSET, 8'h91);
        check("lcd", lcd_segment_pin, 8'h48);
        check("oe6", port6_pin_oe, 8'h85);
        check("pull6", port6_pullup_on, 8'h32);
        check("out6", port6_pin_out & port6_pin_oe, 8'h84);
        check("sck idle", {7'h0, serial_clock_in}, 8'h01);
        wr(PORT6_PULLUP_OFFSET, 8'h0f);
        check("pull6 mask", port6_pullup_on, 8'h02);
        // Pin 6.3 output with its enable bit set: pull-up must drop
        wr(PORT6_LOW_OFFSET, 8'hd1);
        check("oe6 pin3 out", port6_pin_oe, 8'h8d);
        check("pull6 forced", port6_pullup_on, 8'h02);
    endtask

    // Pad levels sampled back and routed to the serial inputs
    task automatic input_paths();
        wr(PORT6_HIGH_OFFSET, 8'h00);
        wr(PORT6_LOW_OFFSET, 8'h00);
        wr(PORT5_HIGH_OFFSET, 8'h00);
        // Pin 5.3 and 5.0 were outputs; release them before driving pads
        wr(PORT5_LOW_OFFSET, 8'h00);
        ext5_drive = 8'hff;
        ext5_level = 8'ha6;
        ext6_drive = 8'hff;
        ext6_level = 8'h3d;
        repeat (4) @(negedge clk);
        check("level5", port5_pin_level, 8'ha6);
        check("level6", port6_pin_level, 8'h3d);
        check("si low", {7'h0, serial_data_in}, 8'h00);
        check("sck high", {7'h0, serial_clock_in}, 8'h01);
        ext6_level = 8'h3e;
        repeat (4) @(negedge clk);
        check("si high", {7'h0, serial_data_in}, 8'h01);
        check("sck low", {7'h0, serial_clock_in}, 8'h00);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        reset_values();
        reg_access();
        do_reset();
        reset_values();
        port5_modes();
        port6_modes();
        input_paths();
        tally_and_finish();
    end
endmodule
